// ===== design/tci_sync.sv
/*
  Two-flop level synchroniser, parameterised width.
  Assumes inputs are asynchronous to i_clk; the first stage feeds only the second.
*/
`timescale 1ns/1ps
module tci_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // reset to idle-high so no false edge appears at release
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule // tci_sync

// ===== design/tci_target.sv
/*
  Host-facing serial target port: address match, write receive with acknowledge,
  read transmit with clock stretching, data-ready line, straps and status LED.
  Assumes host bus controller on SCL/SDA; pin levels resolved outside from enables.
*/
`timescale 1ns/1ps
module tci_target
  import tci_pkg::*;
#(
  parameter int LED_SLOW_CYC = LED_SLOW_HALF_CYC,
  parameter int LED_FAST_CYC = LED_FAST_HALF_CYC
) (
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic i_SCL,
  input wire logic i_SDA,
  output logic o_SCL_OUT,
  output logic o_SCL_OE,
  output logic o_SDA_OUT,
  output logic o_SDA_OE,
  input wire logic i_IFACE_SELECT_STRAP,
  input wire logic i_SENSOR_TYPE_STRAP,
  input wire logic i_TOUCH_OPTION_CONFIG,
  input wire logic i_TOUCH_ACTIVE,
  input wire logic i_DATA_PENDING,
  input wire logic [7:0] i_TX_DATA,
  input wire logic i_TX_VALID,
  output logic o_TX_TAKEN,
  output logic [7:0] o_RX_DATA,
  output logic o_RX_VALID,
  output logic o_DATA_READY_IRQ,
  output logic o_SERIAL_MODE,
  output logic o_SENSOR_5WIRE,
  output logic o_SENSOR_8WIRE,
  output logic o_LED
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  tci_lines_s lines;
  tci_straps_s straps;
  tci_lines_s prev_q;
  logic [3:0] pins_sync;

  tci_sync #(.WIDTH(4)) u_sync (
    .i_clk(I_CLK),
    .i_nrst(I_NRST),
    .i_async({i_SCL, i_SDA, i_IFACE_SELECT_STRAP, i_SENSOR_TYPE_STRAP}),
    .o_sync(pins_sync)
  );

  // split the synchronised pins into bus lines and straps
  assign lines = tci_lines_s'(pins_sync[3:2]);
  assign straps = tci_straps_s'(pins_sync[1:0]);

  // edge and bus condition decode on synchronised lines
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  assign scl_rise = lines.scl & ~prev_q.scl;
  assign scl_fall = ~lines.scl & prev_q.scl;
  assign start_cond = lines.scl & prev_q.scl & prev_q.sda & ~lines.sda;
  assign stop_cond = lines.scl & prev_q.scl & ~prev_q.sda & lines.sda;

  // ----------------------------------------------------------------
  // strap capture, once after reset release
  // ----------------------------------------------------------------
  logic strap_done_q;
  logic strap_done_d;
  tci_straps_s strap_q;
  tci_straps_s strap_d;
  logic [1:0] strap_cnt_q;
  logic [1:0] strap_cnt_d;

  // wait out the synchroniser: its reset level would read as a high interface strap
  always_comb begin
    strap_cnt_d = strap_done_q ? strap_cnt_q : strap_cnt_q + 2'h1;
    strap_done_d = strap_done_q | (strap_cnt_q == STRAP_SETTLE_CYC);
    strap_d = (!strap_done_q && strap_cnt_q == STRAP_SETTLE_CYC) ? straps : strap_q;
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      strap_done_q <= 1'b0;
      strap_cnt_q <= '0;
      strap_q <= '0;
    end else begin
      strap_done_q <= strap_done_d;
      strap_cnt_q <= strap_cnt_d;
      strap_q <= strap_d;
    end
  end

  logic serial_mode;
  assign serial_mode = strap_done_q & ~strap_q.iface_select_strap; // [R3]

  // ----------------------------------------------------------------
  // bus protocol engine
  // ----------------------------------------------------------------
  tci_state_e st_q;
  tci_state_e st_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [7:0] sh_q;
  logic [7:0] sh_d;
  logic rw_q;
  logic rw_d;
  logic nack_q;
  logic nack_d;
  logic sda_oe_q;
  logic sda_oe_d;
  logic scl_oe_q;
  logic scl_oe_d;
  logic taken_q;
  logic taken_d;
  logic rx_valid_q;
  logic rx_valid_d;
  logic [7:0] rx_q;
  logic [7:0] rx_d;

  // the engine samples at 200 MHz, far above the shortest 1.25 us phase [R2]
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    rw_d = rw_q;
    nack_d = nack_q;
    sda_oe_d = sda_oe_q;
    scl_oe_d = 1'b0;
    taken_d = 1'b0;
    rx_valid_d = 1'b0;
    rx_d = rx_q;
    if (stop_cond) begin
      // lines released at every stop
      st_d = ST_IDLE; // [R4]
      sda_oe_d = 1'b0;
    end else if (start_cond) begin
      // repeated start restarts the address phase
      st_d = ST_ADDR; // [R17]
      cnt_d = '0;
      sda_oe_d = 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          sda_oe_d = 1'b0;
        end
        ST_ADDR, ST_WR_BYTE: begin
          if (scl_rise && cnt_q != BITS_PER_BYTE) begin
            sh_d = {sh_q[6:0], lines.sda}; // [R5] [R16]
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
            cnt_d = '0;
            if (st_q == ST_WR_BYTE) begin
              sda_oe_d = 1'b1; // [R14]
              rx_d = sh_q;
              rx_valid_d = 1'b1;
              st_d = ST_WR_ACK;
            end else if (serial_mode && sh_q[7:1] == TARGET_ADDR) begin // [R1]
              sda_oe_d = 1'b1; // [R14]
              rw_d = sh_q[0];
              st_d = ST_ADDR_ACK;
            end else begin
              st_d = ST_IGNORE; // [R17]
            end
          end
        end
        ST_ADDR_ACK, ST_WR_ACK: begin
          if (scl_fall) begin
            sda_oe_d = 1'b0;
            st_d = (st_q == ST_ADDR_ACK && rw_q) ? ST_RD_LOAD : ST_WR_BYTE;
            scl_oe_d = (st_q == ST_ADDR_ACK && rw_q);
          end
        end
        ST_RD_LOAD: begin
          // hold the clock low until a byte is offered; stall reaches the host
          if (i_TX_VALID) begin
            sh_d = i_TX_DATA;
            sda_oe_d = ~i_TX_DATA[7]; // [R16]
            taken_d = 1'b1;
            cnt_d = '0;
            st_d = ST_RD_BYTE;
          end else begin
            scl_oe_d = 1'b1; // [R15]
          end
        end
        ST_RD_BYTE: begin
          if (scl_fall) begin
            if (cnt_q == BITS_PER_BYTE - 4'h1) begin
              sda_oe_d = 1'b0;
              st_d = ST_RD_ACK;
            end else begin
              sda_oe_d = ~sh_q[6]; // [R6]
              sh_d = {sh_q[6:0], 1'b0};
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            nack_d = lines.sda;
          end else if (scl_fall) begin
            st_d = nack_q ? ST_IGNORE : ST_RD_LOAD;
            scl_oe_d = ~nack_q; // [R15]
          end
        end
        ST_IGNORE: begin
          sda_oe_d = 1'b0; // [R17]
        end
        default: begin
          st_d = ST_IDLE;
          sda_oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      prev_q <= '1;
      st_q <= ST_IDLE;
      cnt_q <= '0;
      sh_q <= '0;
      rw_q <= 1'b0;
      nack_q <= 1'b1;
      sda_oe_q <= RST_LINE_RELEASE;
      scl_oe_q <= RST_LINE_RELEASE;
      taken_q <= 1'b0;
      rx_valid_q <= 1'b0;
      rx_q <= '0;
    end else begin
      prev_q <= lines;
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      rw_q <= rw_d;
      nack_q <= nack_d;
      sda_oe_q <= sda_oe_d;
      scl_oe_q <= scl_oe_d;
      taken_q <= taken_d;
      rx_valid_q <= rx_valid_d;
      rx_q <= rx_d;
    end
  end

  // ----------------------------------------------------------------
  // data ready, sensor selection and status LED
  // ----------------------------------------------------------------
  logic irq_q;
  logic irq_d;
  logic s5_q;
  logic s5_d;
  logic s8_q;
  logic s8_d;
  logic mode_q;
  logic [31:0] slow_cnt_q;
  logic [31:0] slow_cnt_d;
  logic [31:0] fast_cnt_q;
  logic [31:0] fast_cnt_d;
  logic slow_q;
  logic slow_d;
  logic fast_q;
  logic fast_d;
  logic led_q;
  logic led_d;

  always_comb begin
    irq_d = i_DATA_PENDING; // [R7] [R8]
    s5_d = strap_done_q & strap_q.sensor_type_strap; // [R9]
    // software config only matters with 4/8-wire strapping; default 4-wire
    s8_d = strap_done_q & ~strap_q.sensor_type_strap & i_TOUCH_OPTION_CONFIG; // [R10]
    slow_cnt_d = slow_cnt_q + 32'h1;
    slow_d = slow_q;
    if (slow_cnt_q >= 32'(LED_SLOW_CYC - 1)) begin
      slow_cnt_d = '0;
      slow_d = ~slow_q;
    end
    fast_cnt_d = fast_cnt_q + 32'h1;
    fast_d = fast_q;
    if (fast_cnt_q >= 32'(LED_FAST_CYC - 1)) begin
      fast_cnt_d = '0;
      fast_d = ~fast_q;
    end
    if (i_TOUCH_ACTIVE) begin
      led_d = fast_d; // [R12]
    end else if (serial_mode) begin
      led_d = slow_d; // [R11]
    end else begin
      led_d = 1'b0; // [R13]
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      irq_q <= RST_DATA_READY;
      s5_q <= 1'b0;
      s8_q <= 1'b0;
      mode_q <= 1'b0;
      slow_cnt_q <= '0;
      fast_cnt_q <= '0;
      slow_q <= 1'b0;
      fast_q <= 1'b0;
      led_q <= RST_LED;
    end else begin
      irq_q <= irq_d;
      s5_q <= s5_d;
      s8_q <= s8_d;
      mode_q <= serial_mode;
      slow_cnt_q <= slow_cnt_d;
      fast_cnt_q <= fast_cnt_d;
      slow_q <= slow_d;
      fast_q <= fast_d;
      led_q <= led_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs from flops, pin levels tied low; open-drain drives only low
  // ----------------------------------------------------------------
  assign o_SCL_OUT = RST_LINE_RELEASE;
  assign o_SDA_OUT = RST_LINE_RELEASE;
  assign o_SCL_OE = scl_oe_q;
  assign o_SDA_OE = sda_oe_q;
  assign o_TX_TAKEN = taken_q;
  assign o_RX_DATA = rx_q;
  assign o_RX_VALID = rx_valid_q;
  assign o_DATA_READY_IRQ = irq_q;
  assign o_SERIAL_MODE = mode_q;
  assign o_SENSOR_5WIRE = s5_q;
  assign o_SENSOR_8WIRE = s8_q;
  assign o_LED = led_q;

endmodule // tci_target

// ===== shared/tci_pkg.sv
/*
  Shared constants and types of the touch controller serial target port.
  Assumes a 200 MHz system clock and a host bus controller on the far side.
*/
// Overview of operation
// (R1) answer only at 7-bit target address 0x4D, pattern 1001101
// (R2) bus runs at up to 400 kHz; the port works at any lower rate
// (R3) interface strap low selects the two-wire serial host port
// (R4) both lines open-drain and idle high; no low hold outside transfers
// (R5) host write bits are sampled on rising clock edges
// (R6) read data changes on falling clock edges, stable while clock high
// (R7) data-ready output is driven, not open-drain, and rests low
// (R8) data-ready goes high while a report or response awaits the host
// (R9) sensor strap low picks 4/8-wire, high picks 5-wire
// (R10) 4/8-wire strapping defaults to 4-wire; 8-wire only by software config
// (R11) serial mode, no touch: status LED blinks slowly
// (R12) touch in progress: status LED toggles rapidly, medium brightness
// (R13) other interface selected: LED off without touch, rapid with touch
// (R14) target pulls data low in ninth clock to acknowledge address and writes
// (R15) target may hold clock low to stall; host waits for its release
// (R16) bytes go most significant bit first, eight consecutive bits
// (R17) address mismatch: data released, transfer ignored until next start
package tci_pkg;

  // ----------------------------------------------------------------
  // addressing and timing
  // ----------------------------------------------------------------
  localparam logic [6:0] TARGET_ADDR = 7'h4D;
  localparam int SYS_CLK_MHZ = 200;
  localparam int BUS_MAX_KHZ = 400;
  // clock samples per shortest bus clock phase at the top rate
  localparam int BUS_MIN_PHASE_NS = 1250;
  localparam int BUS_MIN_PHASE_CYC = (BUS_MIN_PHASE_NS * SYS_CLK_MHZ) / 1000;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // edges after reset release before the synchronised straps show real pin levels
  localparam logic [1:0] STRAP_SETTLE_CYC = 2'h2;

  // status LED timing
  localparam int LED_SLOW_HALF_MS = 250;
  localparam int LED_SLOW_HALF_CYC = LED_SLOW_HALF_MS * SYS_CLK_MHZ * 1000;
  localparam int LED_FAST_HALF_US = 10;
  localparam int LED_FAST_HALF_CYC = LED_FAST_HALF_US * SYS_CLK_MHZ;

  // reset values
  localparam logic RST_LINE_RELEASE = 1'b0;
  localparam logic RST_DATA_READY = 1'b0;
  localparam logic RST_LED = 1'b0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR_BYTE, ST_WR_ACK,
    ST_RD_LOAD, ST_RD_BYTE, ST_RD_ACK, ST_IGNORE
  } tci_state_e;

  typedef struct packed {
    logic scl;
    logic sda;
  } tci_lines_s;

  typedef struct packed {
    logic iface_select_strap;
    logic sensor_type_strap;
  } tci_straps_s;

endpackage : tci_pkg

// ===== verification/tb_touch_ctrl_i2c_target_port.sv
/* bench of the target port: host model on the lines, queue of written bytes
   assumes 200 MHz clock and shortened light counts */
`timescale 1ns/1ps
module tb_touch_ctrl_i2c_target_port;
  logic clk, nrst, scl, sda, scl_oe, sda_oe, h_scl, h_sda, s_if, s_5w, cfg, touch;
  logic pend, tx_v, taken, rx_v, irq, ser, w5, w8, led, a;
  logic [7:0] tx_d, rx_d, q, d;
  int num_errors, checked;
  int rx_q[$];
  // ----
  // lines, clock, instances
  // ----
  // open-drain wires: low if any party pulls
  assign scl = !(h_scl || scl_oe);
  assign sda = !(h_sda || sda_oe);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = !clk;
  end
  tci_host host_u (.i_scl(scl), .i_sda(sda), .o_scl_low(h_scl), .o_sda_low(h_sda));
  tci_target #(.LED_SLOW_CYC(40), .LED_FAST_CYC(4)) dut_u (.I_CLK(clk), .I_NRST(nrst),
    .i_SCL(scl), .i_SDA(sda), .o_SCL_OUT(), .o_SCL_OE(scl_oe), .o_SDA_OUT(),
    .o_SDA_OE(sda_oe), .i_IFACE_SELECT_STRAP(s_if), .i_SENSOR_TYPE_STRAP(s_5w),
    .i_TOUCH_OPTION_CONFIG(cfg), .i_TOUCH_ACTIVE(touch), .i_DATA_PENDING(pend),
    .i_TX_DATA(tx_d), .i_TX_VALID(tx_v), .o_TX_TAKEN(taken), .o_RX_DATA(rx_d),
    .o_RX_VALID(rx_v), .o_DATA_READY_IRQ(irq), .o_SERIAL_MODE(ser),
    .o_SENSOR_5WIRE(w5), .o_SENSOR_8WIRE(w8), .o_LED(led));
  // ----
  // tasks
  // ----
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // straps held from reset until well after release
  task automatic rst(input logic i_f, input logic s5);
    @(posedge clk);
    nrst <= 1'b0;
    pend <= 1'b0;
    s_if <= i_f;
    s_5w <= s5;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  task automatic xa(input logic [6:0] ad, input logic rw, input logic e);
    host_u.start();
    host_u.xfer({ad, rw}, 1'b1, q, a);
    check({7'h0, a}, {7'h0, e});
  endtask
  // offer late so the port has to stretch
  task automatic offer(input logic [7:0] v);
    int n;
    repeat (30) @(posedge clk);
    tx_d <= v;
    tx_v <= 1'b1;
    for (n = 0; n < 99 && taken !== 1'b1; n++) @(posedge clk);
    tx_v <= 1'b0;
  endtask
  // cycles between two light toggles; 200 means none
  task automatic led_gap(input logic [7:0] exp);
    int n;
    int g;
    logic l;
    l = led;
    for (n = 0; n < 200 && led === l; n++) @(posedge clk);
    l = led;
    for (g = 0; g < 200 && led === l; g++) @(posedge clk);
    check(g[7:0], exp);
  endtask
  // each written byte matches the oldest queued one
  always @(posedge clk) begin
    if (rx_v === 1'b1) begin
      check(8'(rx_q.size()), 8'h01);
      if (rx_q.size() > 0) check(rx_d, 8'(rx_q.pop_front()));
    end
  end
  // ----
  // tests
  // ----
  // watchdog: whole run needs well under 100 us
  initial begin
    #200000;
    num_errors++;
    print_verdict();
  end
  initial begin
    nrst = 1'b0;
    s_if = 1'b0;
    s_5w = 1'b0;
    cfg = 1'b0;
    touch = 1'b0;
    pend = 1'b0;
    tx_v = 1'b0;
    tx_d = 8'h00;
    void'($urandom(6355));
    for (int s = 0; s < 2; s++) begin
      rst(1'b0, s[0]);
      check({7'h0, ser}, 8'h01);
      check({6'h0, w5, w8}, {6'h0, s[0], 1'b0});
      cfg <= 1'b1;
      repeat (3) @(posedge clk);
      check({7'h0, w8}, {7'h0, !s[0]});
      cfg <= 1'b0;
    end
    $display("test straps done");
    repeat (16) begin
      d = 8'($urandom);
      pend <= d[0];
      repeat (2) @(posedge clk);
      check({7'h0, irq}, {7'h0, d[0]});
    end
    $display("test data-ready done");
    xa(7'h4D, 1'b0, 1'b0);
    repeat (3) begin
      d = 8'($urandom);
      rx_q.push_back(d);
      host_u.xfer(d, 1'b1, q, a);
      check({7'h0, a}, 8'h00);
    end
    host_u.stop();
    for (int i = 0; i < 7; i++) begin
      xa(7'h4D ^ 7'(1 << i), 1'b0, 1'b1);
      host_u.xfer(8'h00, 1'b1, q, a);
      check({7'h0, a}, 8'h01);
      host_u.stop();
    end
    repeat (8) @(posedge clk);
    check(8'(rx_q.size()), 8'h00);
    $display("test write done");
    xa(7'h4D, 1'b1, 1'b0);
    for (int k = 0; k < 2; k++) begin
      d = 8'($urandom);
      fork
        host_u.xfer(8'hFF, k[0], q, a);
        offer(d);
      join
      check(q, d);
    end
    host_u.stop();
    $display("test read done");
    led_gap(8'h28);
    touch <= 1'b1;
    led_gap(8'h04);
    touch <= 1'b0;
    rst(1'b1, 1'b0);
    check({7'h0, ser}, 8'h00);
    xa(7'h4D, 1'b0, 1'b1);
    host_u.stop();
    led_gap(8'hC8);
    touch <= 1'b1;
    led_gap(8'h04);
    $display("test light done");
    print_verdict();
  end
endmodule // tb_touch_ctrl_i2c_target_port

// ===== verification/tci_host.sv
/* host bus controller model on the two open-drain lines
   assumes the bench resolves levels with pull-ups */
`timescale 1ns/1ps
module tci_host (
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_low,
  output logic o_sda_low
);
  // ----
  // bus phases, 48 ns bit
  // ----
  // lines released at rest so pull-ups hold them high
  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
  end
  // data set mid low phase, sampled late in high phase
  task automatic bit_io(input logic b, output logic r);
    int n;
    #12 o_sda_low = !b;
    #12 o_scl_low = 1'b0;
    // wait out a stretched clock, bounded
    for (n = 0; n < 999 && i_scl !== 1'b1; n++) #5;
    #20 r = i_sda;
    #4 o_scl_low = 1'b1;
  endtask
  // eight bits msb first, then the acknowledge clock
  task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q,
                      output logic a);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ak, a);
  endtask
  // start and stop: data moves while clock high
  task automatic start();
    o_sda_low = 1'b1;
    #24 o_scl_low = 1'b1;
  endtask
  task automatic stop();
    #12 o_sda_low = 1'b1;
    #12 o_scl_low = 1'b0;
    #24 o_sda_low = 1'b0;
    #24;
  endtask
endmodule // tci_host

// ===== verification/tci_target_chk.sv
/* assertions on the target port pins
   assumes one clock domain, bound to tci_target */
`timescale 1ns/1ps
module tci_target_chk (
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic i_SCL,
  input wire logic i_TX_VALID,
  input wire logic i_DATA_PENDING,
  input wire logic i_TOUCH_ACTIVE,
  input wire logic o_SCL_OUT,
  input wire logic o_SCL_OE,
  input wire logic o_SDA_OUT,
  input wire logic o_SDA_OE,
  input wire logic o_TX_TAKEN,
  input wire logic o_RX_VALID,
  input wire logic o_DATA_READY_IRQ,
  input wire logic o_SERIAL_MODE,
  input wire logic o_SENSOR_5WIRE,
  input wire logic o_SENSOR_8WIRE,
  input wire logic o_LED
);
  // ----
  // properties
  // ----
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  // byte taken only when offered, strobe one cycle
  sequence s_take;
    $past(i_TX_VALID) ##1 !o_TX_TAKEN;
  endsequence
  // stretch ends soon once data is offered
  sequence s_unstretch;
    ##[1:3] !o_SCL_OE;
  endsequence
  irq_follow_a: assert property (o_DATA_READY_IRQ == $past(i_DATA_PENDING))
    else $error("data-ready not one cycle behind pending");
  open_drain_a: assert property (!o_SCL_OUT && !o_SDA_OUT)
    else $error("line drives a high level");
  quiet_other_a: assert property (!o_SERIAL_MODE |-> !o_SDA_OE && !o_SCL_OE)
    else $error("lines pulled outside serial mode");
  sensor_one_a: assert property (o_SENSOR_8WIRE |-> !o_SENSOR_5WIRE)
    else $error("8-wire with 5-wire strap");
  tx_take_a: assert property ($rose(o_TX_TAKEN) |-> s_take)
    else $error("byte taken without offer");
  stretch_end_a: assert property (o_SCL_OE && i_TX_VALID |-> s_unstretch)
    else $error("clock held after data offered");
  sda_edge_a: assert property ($changed(o_SDA_OE) |-> !$past(i_SCL, 2))
    else $error("data moved while clock high");
  rx_pulse_a: assert property (o_RX_VALID |=> !o_RX_VALID)
    else $error("receive strobe longer than a cycle");
  led_off_a: assert property ((!o_SERIAL_MODE && !i_TOUCH_ACTIVE) [*3] |-> !o_LED)
    else $error("light on without touch");
endmodule // tci_target_chk

bind tci_target tci_target_chk chk_u (.I_CLK, .I_NRST, .i_SCL, .i_TX_VALID,
  .i_DATA_PENDING, .i_TOUCH_ACTIVE, .o_SCL_OUT, .o_SCL_OE, .o_SDA_OUT, .o_SDA_OE,
  .o_TX_TAKEN, .o_RX_VALID, .o_DATA_READY_IRQ, .o_SERIAL_MODE, .o_SENSOR_5WIRE,
  .o_SENSOR_8WIRE, .o_LED);
